// ### hw/epc_counter_bank.v
`timescale 1ns/10ps
`default_nettype none
`include "epc_consts.vh"

// How it works
// [RQ1] Eight identical units, each with own settings, counter, watchpoints.
// [RQ2] Each unit keeps a 16-bit signed up/down counter, readable directly.
// [RQ3] Two equal channels per unit, each with signal and control input.
// [RQ4] Edge action 1 counts up, 2 counts down, others do nothing.
// [RQ5] Low-level modifier applies when control low, high-level when high.
// [RQ6] Modifier 0 keeps, 1 swaps direction, others block counting.
// [RQ7] Falling edges follow the same scheme with their own action.
// [RQ8] One per-unit enable turns on filters of all four inputs.
// [RQ9] Enabled filter drops pulses shorter than programmed cycle count.
// [RQ10] All inputs sampled on clock edges; shorter pulses may be missed.
// [RQ11] Freeze holds the counter and ignores counting events.
// [RQ12] Clear forces the counter to zero.
// [RQ13] Five watchpoints per unit share one interrupt.
// [RQ14] Each watchpoint has its own enable.
// [RQ15] Counter at or above high limit fires and returns to zero.
// [RQ16] Counter at or below low limit fires and returns to zero.
// [RQ17] Counter equal to either threshold, or to zero, fires a watchpoint.
// [RQ18] Interrupt raised when any enabled watchpoint matches.
// [RQ19] Edges found from consecutive filtered samples; control taken same cycle.
// [RQ20] Both channels acting in one cycle apply their net sum.
module epc_counter_bank #(
  parameter UNITS = `EPC_UNITS,
  parameter CNT_W = `EPC_CNT_W,
  parameter FLT_W = `EPC_FLT_W
) (
  // Clock and reset
  input  wire                     clock,
  input  wire                     arst_n,
  // Pad inputs, two per unit for each kind
  input  wire [2*UNITS-1:0]       sig_in,
  input  wire [2*UNITS-1:0]       ctl_in,
  // Per-channel settings, 2 bits each
  input  wire [4*UNITS-1:0]       rise_edge_action,
  input  wire [4*UNITS-1:0]       fall_edge_action,
  input  wire [4*UNITS-1:0]       low_level_modifier,
  input  wire [4*UNITS-1:0]       high_level_modifier,
  // Per-unit filter controls
  input  wire [UNITS-1:0]         glitch_filter_enable,
  input  wire [FLT_W*UNITS-1:0]   glitch_filter_cycles,
  // Per-unit software control
  input  wire [UNITS-1:0]         count_freeze,
  input  wire [UNITS-1:0]         count_clear,
  // Per-unit watchpoint settings
  input  wire [CNT_W*UNITS-1:0]   high_limit,
  input  wire [CNT_W*UNITS-1:0]   low_limit,
  input  wire [CNT_W*UNITS-1:0]   threshold_a,
  input  wire [CNT_W*UNITS-1:0]   threshold_b,
  input  wire [5*UNITS-1:0]       watch_enable,
  // Status
  output wire [CNT_W*UNITS-1:0]   edge_tally,
  output wire [5*UNITS-1:0]       watch_hit,
  output wire [UNITS-1:0]         watchpoint_irq
);

  genvar u;
  genvar c;

  // ****************************************
  // Counting units
  // ****************************************
  generate
    for (u = 0; u < UNITS; u = u + 1)
    begin : g_unit                                    // [RQ1]
      wire [1:0]       fsig;
      wire [1:0]       fctl;
      wire [3:0]       dlt;
      reg  [CNT_W-1:0] cnt_q;
      reg  [4:0]       hit_q;
      reg  [CNT_W-1:0] sum;
      reg  [CNT_W-1:0] nxt;
      reg  [4:0]       hit;
      wire [CNT_W-1:0] hi = high_limit[CNT_W*u +: CNT_W];
      wire [CNT_W-1:0] lo = low_limit[CNT_W*u +: CNT_W];

      for (c = 0; c < 2; c = c + 1)
      begin : g_ch                                    // [RQ3]
        // Same enable for all four filters of the unit
        epc_glitch_filter #(.FLT_W(FLT_W)) u_fs (
          .clock  (clock),
          .arst_n (arst_n),
          .enable (glitch_filter_enable[u]),          // [RQ8]
          .cycles (glitch_filter_cycles[FLT_W*u +: FLT_W]),
          .din    (sig_in[2*u+c]),
          .dout_q (fsig[c])
        );
        epc_glitch_filter #(.FLT_W(FLT_W)) u_fc (
          .clock  (clock),
          .arst_n (arst_n),
          .enable (glitch_filter_enable[u]),          // [RQ8]
          .cycles (glitch_filter_cycles[FLT_W*u +: FLT_W]),
          .din    (ctl_in[2*u+c]),
          .dout_q (fctl[c])
        );
        epc_channel u_ch (
          .clock               (clock),
          .arst_n              (arst_n),
          .sig                 (fsig[c]),
          .ctl                 (fctl[c]),
          .rise_edge_action    (rise_edge_action[4*u+2*c +: 2]),
          .fall_edge_action    (fall_edge_action[4*u+2*c +: 2]),
          .low_level_modifier  (low_level_modifier[4*u+2*c +: 2]),
          .high_level_modifier (high_level_modifier[4*u+2*c +: 2]),
          .delta               (dlt[2*c +: 2])
        );
      end

      // Next count and watchpoint matches
      always @*
      begin
        sum = cnt_q;
        if (dlt[0])
          sum = sum + {{(CNT_W-1){1'b0}}, 1'b1};
        if (dlt[1])
          sum = sum - {{(CNT_W-1){1'b0}}, 1'b1};
        if (dlt[2])
          sum = sum + {{(CNT_W-1){1'b0}}, 1'b1};    // [RQ20]
        if (dlt[3])
          sum = sum - {{(CNT_W-1){1'b0}}, 1'b1};    // [RQ20]
        if (count_freeze[u])
          sum = cnt_q;                                // [RQ11]
        hit = 5'h00;
        hit[`EPC_WP_HIGH] = ($signed(sum) >= $signed(hi));             // [RQ15]
        hit[`EPC_WP_LOW]  = ($signed(sum) <= $signed(lo));             // [RQ16]
        hit[`EPC_WP_THRA] = (sum == threshold_a[CNT_W*u +: CNT_W]);    // [RQ17]
        hit[`EPC_WP_THRB] = (sum == threshold_b[CNT_W*u +: CNT_W]);    // [RQ17]
        hit[`EPC_WP_ZERO] = (sum == {CNT_W{1'b0}});                    // [RQ17]
        // Only a change of the count fires, so a held value does not repeat
        if (sum == cnt_q)
          hit = 5'h00;
        nxt = sum;
        // Limits wrap the count even when their watchpoint is masked
        if (hit[`EPC_WP_HIGH] || hit[`EPC_WP_LOW])
          nxt = {CNT_W{1'b0}};                        // [RQ15] [RQ16]
        hit = hit & watch_enable[5*u +: 5];                            // [RQ14]
        if (count_clear[u])
        begin
          nxt = {CNT_W{1'b0}};                        // [RQ12]
          hit = 5'h00;
        end
      end

      always @(posedge clock or negedge arst_n)
      begin
        if (!arst_n)
        begin
          cnt_q <= {CNT_W{1'b0}};
          hit_q <= 5'h00;
        end
        else
        begin
          cnt_q <= nxt;                               // [RQ2]
          hit_q <= hit;
        end
      end

      assign edge_tally[CNT_W*u +: CNT_W] = cnt_q;    // [RQ2]
      assign watch_hit[5*u +: 5]          = hit_q;
      assign watchpoint_irq[u]            = |hit_q;   // [RQ13] [RQ18]
    end
  endgenerate

endmodule

`default_nettype wire

// ### hw/epc_consts.vh
`ifndef EPC_CONSTS_VH
`define EPC_CONSTS_VH

// ****************************************
// Edge and modifier encodings
// ****************************************
`define EPC_ACT_INC       2'h1
`define EPC_ACT_DEC       2'h2
`define EPC_MOD_KEEP      2'h0
`define EPC_MOD_INV       2'h1

// ****************************************
// Sizes and reset values
// ****************************************
`define EPC_UNITS         8
`define EPC_CNT_W         16
`define EPC_FLT_W         10
`define EPC_CNT_ZERO      16'h0000
`define EPC_FLT_RST       10'h010

// ****************************************
// Watchpoint bit positions
// ****************************************
`define EPC_WP_NUM        5
`define EPC_WP_THRB       0
`define EPC_WP_THRA       1
`define EPC_WP_LOW        2
`define EPC_WP_HIGH       3
`define EPC_WP_ZERO       4

`endif

// ### hw/epc_glitch_filter.v
`timescale 1ns/10ps
`default_nettype none
`include "epc_consts.vh"

// ****************************************
// One-input glitch filter
// ****************************************
module epc_glitch_filter #(
  parameter FLT_W = `EPC_FLT_W
) (
  // Clock and reset
  input  wire             clock,
  input  wire             arst_n,
  // Control
  input  wire             enable,
  input  wire [FLT_W-1:0] cycles,
  // Data
  input  wire             din,
  output reg              dout_q
);

  reg             samp_q;
  reg [FLT_W-1:0] run_q;

  // Input is accepted only after it has stood stable for the programmed count
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      samp_q <= 1'b0;
      run_q  <= {FLT_W{1'b0}};
      dout_q <= 1'b0;
    end
    else
    begin
      samp_q <= din;                                  // [RQ10]
      if (!enable)
      begin
        run_q  <= {FLT_W{1'b0}};
        dout_q <= samp_q;
      end
      else if (samp_q == dout_q)
        run_q <= {FLT_W{1'b0}};
      else if (run_q + {{(FLT_W-1){1'b0}}, 1'b1} >= cycles)
      begin
        run_q  <= {FLT_W{1'b0}};
        dout_q <= samp_q;                             // [RQ9]
      end
      else
        run_q <= run_q + {{(FLT_W-1){1'b0}}, 1'b1};   // [RQ9]
    end
  end

endmodule

`default_nettype wire

// ### hw/epc_channel.v
`timescale 1ns/10ps
`default_nettype none
`include "epc_consts.vh"

// ****************************************
// One channel: edge detect and action decode
// ****************************************
module epc_channel (
  // Clock and reset
  input  wire       clock,
  input  wire       arst_n,
  // Filtered inputs
  input  wire       sig,
  input  wire       ctl,
  // Settings
  input  wire [1:0] rise_edge_action,
  input  wire [1:0] fall_edge_action,
  input  wire [1:0] low_level_modifier,
  input  wire [1:0] high_level_modifier,
  // Result
  output reg  [1:0] delta
);

  reg       prev_q;
  reg [1:0] act;
  reg [1:0] modf;
  wire      rise = sig & ~prev_q;
  wire      fall = ~sig & prev_q;

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      prev_q <= 1'b0;
    else
      prev_q <= sig;                                  // [RQ19]
  end

  // delta: 01 up, 10 down, 00 none
  always @*
  begin
    act   = rise ? rise_edge_action : (fall ? fall_edge_action : 2'h0);   // [RQ4] [RQ7]
    modf  = ctl ? high_level_modifier : low_level_modifier;               // [RQ5] [RQ19]
    delta = 2'h0;
    if (act == `EPC_ACT_INC || act == `EPC_ACT_DEC)
    begin
      if (modf == `EPC_MOD_KEEP)
        delta = act;                                  // [RQ6]
      else if (modf == `EPC_MOD_INV)
        delta = {act[0], act[1]};                     // [RQ6]
    end
  end

endmodule

`default_nettype wire

// ### verif/epc_pad_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Pad side: levels held whole clock cycles
// ****
module epc_pad_model (
  // Clock
  input  wire logic        clock,
  // Pads
  output var  logic [15:0] sig,
  output var  logic [15:0] ctl
);
  initial
  begin
    sig = 16'h0000;
    ctl = 16'h0000;
  end
  task automatic set_ctl(input logic [15:0] v);
    @(posedge clock) #1 ctl = v;
  endtask
  // Long tail so filter and pipeline settle
  task automatic pulse(input logic [15:0] m, input int w);
    @(posedge clock) #1 sig = sig | m;
    repeat (w) @(posedge clock);
    #1 sig = sig & ~m;
    repeat (16) @(posedge clock);
    #1;
  endtask
endmodule
`default_nettype wire

// ### verif/epc_counter_bank_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Unit 0 checks
// ****
module epc_counter_bank_assertions #(
  parameter UNITS = 8,
  parameter CNT_W = 16,
  parameter FLT_W = 10
) (
  input wire logic                     clock,
  input wire logic                     arst_n,
  input wire logic [UNITS-1:0]         count_freeze,
  input wire logic [UNITS-1:0]         count_clear,
  input wire logic [CNT_W*UNITS-1:0]   high_limit,
  input wire logic [CNT_W*UNITS-1:0]   low_limit,
  input wire logic [CNT_W*UNITS-1:0]   threshold_a,
  input wire logic [5*UNITS-1:0]       watch_enable,
  input wire logic [CNT_W*UNITS-1:0]   edge_tally,
  input wire logic [5*UNITS-1:0]       watch_hit,
  input wire logic [UNITS-1:0]         watchpoint_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  irq_or_a: assert property (
    watchpoint_irq[0] == |watch_hit[4:0])
    else $error("irq mismatch");
  freeze_hold_a: assert property (
    count_freeze[0] && !count_clear[0] |=> $stable(edge_tally[15:0]))
    else $error("freeze moved count");
  clear_zero_a: assert property (
    count_clear[0] |=> edge_tally[15:0] == 16'h0000)
    else $error("clear not zero");
  clear_quiet_a: assert property (
    count_clear[0] |=> watch_hit[4:0] == 5'h00)
    else $error("hit during clear");
  enable_gate_a: assert property (
    |watch_hit[4:0] |-> (watch_hit[4:0] & ~$past(watch_enable[4:0])) == 5'h00)
    else $error("disabled hit");
  zero_val_a: assert property (
    watch_hit[4] |-> edge_tally[15:0] == 16'h0000)
    else $error("zero hit off zero");
  limit_zero_a: assert property (
    watch_hit[3] || watch_hit[2] |-> edge_tally[15:0] == 16'h0000)
    else $error("limit no wrap");
  // Threshold strictly inside the limits, so no wrap can hide it
  thr_val_a: assert property (
    watch_hit[1]
    && $signed($past(threshold_a[15:0])) < $signed($past(high_limit[15:0]))
    && $signed($past(threshold_a[15:0])) > $signed($past(low_limit[15:0]))
    |-> edge_tally[15:0] == $past(threshold_a[15:0]))
    else $error("threshold value");
endmodule
bind epc_counter_bank epc_counter_bank_assertions #(
  .UNITS(UNITS), .CNT_W(CNT_W), .FLT_W(FLT_W)) i_chk (
  .clock, .arst_n, .count_freeze, .count_clear, .high_limit, .low_limit,
  .threshold_a, .watch_enable, .edge_tally, .watch_hit, .watchpoint_irq);
`default_nettype wire

// ### verif/epc_counter_bank_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; \
  if ((a) !== (e)) begin n_fail++; \
  $display("Error %s exp %0h got %0h", n, e, a); end end
// ****
// Bench
// ****
module epc_counter_bank_tb_top;
  logic         clock = 1'b0;
  logic         arst_n = 1'b0;
  logic [31:0]  ra, fa, lm, hm;
  logic [7:0]   fen, frz, clr;
  logic [79:0]  fcy;
  logic [127:0] hl, ll, ta, tb2;
  logic [39:0]  we;
  logic [5:0]   seen = 6'h00;
  logic [15:0]  exp_u [0:7];
  wire  [15:0]  sig, ctl;
  wire  [127:0] tally;
  wire  [39:0]  hit;
  wire  [7:0]   irq;
  int           n_fail = 0;
  int           samples_checked = 0;
  int           u;
  // Rise, fall, low mod, high mod, control level, signed net change
  logic [15:0]  rows [0:12] = '{16'h4001, 16'h800f, 16'h1001, 16'h200f, 16'hf000, 16'h540e,
    16'h6110, 16'h511e, 16'h5800, 16'h5c00, 16'h5210, 16'ha81e, 16'h8310};
  always #5 clock = ~clock;
  // Hits last one cycle, so catch them mid-cycle
  always @(negedge clock) seen = seen | {irq[0], hit[4:0]};
  epc_pad_model i_epc_pad_model (.clock(clock), .sig(sig), .ctl(ctl));
  epc_counter_bank i_epc_counter_bank (.clock(clock), .arst_n(arst_n), .sig_in(sig), .ctl_in(ctl),
    .rise_edge_action(ra), .fall_edge_action(fa), .low_level_modifier(lm),
    .high_level_modifier(hm), .glitch_filter_enable(fen), .glitch_filter_cycles(fcy),
    .count_freeze(frz), .count_clear(clr), .high_limit(hl), .low_limit(ll),
    .threshold_a(ta), .threshold_b(tb2), .watch_enable(we), .edge_tally(tally),
    .watch_hit(hit), .watchpoint_irq(irq));
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #100_000;
    n_fail++;
    final_report;
  end
  initial
  begin
    {ra, fa, lm, hm, fen, frz, clr, we} = '0;
    fcy = {8{10'h004}};
    hl = {8{16'h0064}};
    ll = {8{16'hff9c}};
    ta = {8{16'h0050}};
    tb2 = {8{16'hffb0}};
    for (int k = 0; k < 8; k++) exp_u[k] = 16'h0000;
    repeat (3) @(posedge clock);
    #1 arst_n = 1'b1;
    `CHK("reset tally", 128'h0, tally)
    `CHK("reset hits", 40'h0, hit)
    $display("reset test done");
    for (int i = 0; i < 13; i++)
    begin
      u = i % 8;
      ra = {16{rows[i][15:14]}};
      fa = {16{rows[i][13:12]}};
      lm = {16{rows[i][11:10]}};
      hm = {16{rows[i][9:8]}};
      i_epc_pad_model.set_ctl({16{rows[i][4]}});
      i_epc_pad_model.pulse(16'h0001 << (2 * u + i % 2), 3);
      exp_u[u] = exp_u[u] + {{12{rows[i][3]}}, rows[i][3:0]};
      `CHK("row tally", exp_u[u], tally[16*u +: 16])
    end
    $display("table rows done");
    {fa, lm, hm} = '0;
    ra = {16{2'h1}};
    clr = 8'hff;
    i_epc_pad_model.set_ctl(16'h0000);
    clr = 8'h00;
    `CHK("clear", 128'h0, tally)
    i_epc_pad_model.pulse(16'h0003, 3);
    `CHK("both channels", 16'h0002, tally[15:0])
    frz = 8'h01;
    i_epc_pad_model.pulse(16'h0001, 3);
    frz = 8'h00;
    `CHK("freeze", 16'h0002, tally[15:0])
    fen = 8'h01;
    i_epc_pad_model.pulse(16'h0001, 2);
    `CHK("short glitch", 16'h0002, tally[15:0])
    i_epc_pad_model.pulse(16'h0001, 8);
    `CHK("long pulse", 16'h0003, tally[15:0])
    fen = 8'h00;
    {hl[15:0], ll[15:0], ta[15:0], tb2[15:0]} = {16'h0004, 16'hfffe, 16'h0001, 16'hffff};
    seen = 6'h00;
    i_epc_pad_model.pulse(16'h0001, 3);
    `CHK("disabled hits", 6'h00, seen)
    `CHK("high wrap", 16'h0000, tally[15:0])
    we = {8{5'h1f}};
    repeat (4) i_epc_pad_model.pulse(16'h0001, 3);
    `CHK("high hit", 6'h2a, seen & 6'h2a)
    seen = 6'h00;
    i_epc_pad_model.pulse(16'h0001, 3);
    ra = {16{2'h2}};
    repeat (3) i_epc_pad_model.pulse(16'h0001, 3);
    `CHK("low hit", 6'h37, seen & 6'h37)
    `CHK("low wrap", 16'h0000, tally[15:0])
    $display("hand tests done");
    i_epc_pad_model.pulse(16'h0001, 3);
    `CHK("count before reset", 16'hffff, tally[15:0])
    arst_n = 1'b0;
    #1;
    `CHK("mid-run reset", 128'h0, tally)
    repeat (3) @(posedge clock);
    #1 arst_n = 1'b1;
    `CHK("hits after reset", 40'h0, hit)
    i_epc_pad_model.pulse(16'h0001, 3);
    `CHK("count after reset", 16'hffff, tally[15:0])
    $display("mid-run reset done");
    final_report;
  end
endmodule
`default_nettype wire
